// >>> hdl/tras_pkg.sv
// Package with register map, field positions and carrier types for the result/alert block
package tras_pkg;
    localparam logic [7:0] OFS_TEMP = 8'h00;
    localparam logic [7:0] OFS_SLEW = 8'h01;
    localparam logic [7:0] OFS_ALERT = 8'h02;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam int BIT_CRC = 7;
    localparam int BIT_SLEW_LIVE = 6;
    localparam int BIT_SLEW_FLAG = 5;
    localparam int BIT_HI_LIVE = 4;
    localparam int BIT_LO_LIVE = 3;
    localparam int BIT_HI_FLAG = 2;
    localparam int BIT_LO_FLAG = 1;
    localparam int BIT_READY = 0;
    localparam int SLEW_LSB = 2;
    localparam int NUM_REGS = 3;

    // One finished conversion from the conversion engine
    typedef struct packed {
        logic valid;
        logic [15:0] temp;
        logic [13:0] slew;
    } tras_conv_t;

    // Thresholds from the configuration side
    typedef struct packed {
        logic [15:0] upper_threshold;
        logic [15:0] upper_hysteresis;
        logic [15:0] lower_threshold;
        logic [15:0] lower_hysteresis;
        logic [13:0] slew_limit;
    } tras_limits_t;

    // Register read request from the serial interface
    typedef struct packed {
        logic rd;
        logic burst;
        logic [7:0] addr;
    } tras_rdreq_t;
endpackage

// >>> hdl/tras_regmem.sv
// Small register store for the two result words, with registered read data
`timescale 1ns/100ps
module tras_regmem
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic wr,
    input wire logic [15:0] wr_temp,
    input wire logic [15:0] wr_slew,
    input wire logic rd,
    input wire logic sel,
    output logic [15:0] rd_data
);
    logic [15:0] mem_r [2];
    logic [15:0] mem_nxt [2];
    logic [15:0] rd_data_r;
    logic [15:0] rd_data_nxt;

    // Next memory contents and read word
    always_comb
    begin
        mem_nxt[0] = mem_r[0];
        mem_nxt[1] = mem_r[1];
        rd_data_nxt = rd_data_r;
        if (wr)
        begin
            mem_nxt[0] = wr_temp;
            mem_nxt[1] = wr_slew;
        end
        if (rd)
            rd_data_nxt = mem_r[sel];
    end

    // Both words stored in one edge so they always belong together
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            mem_r[0] <= tras_pkg::RST_WORD;
            mem_r[1] <= tras_pkg::RST_WORD;
            rd_data_r <= tras_pkg::RST_WORD;
        end
        else if (ce)
        begin
            mem_r[0] <= mem_nxt[0];
            mem_r[1] <= mem_nxt[1];
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_data = rd_data_r;
endmodule

// >>> hdl/tras_top.sv
// Result and alert status registers of the temperature sensor core
`timescale 1ns/100ps
module tras_top
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire tras_pkg::tras_conv_t conv,
    input wire tras_pkg::tras_limits_t limits,
    input wire logic crc_wr_done,
    input wire logic crc_wr_fail,
    input wire tras_pkg::tras_rdreq_t rdreq,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic over_temp_live_indicator,
    output logic over_temp_sticky_flag
);
    // ************************************************************
    // Signed compare and address decode helpers
    // ************************************************************
    // Signed greater-than, used for every temperature threshold test
    function automatic logic sgt(input logic [16:0] a, input logic [16:0] b);
        sgt = $signed(a) > $signed(b);
    endfunction

    function automatic logic [16:0] sx(input logic [15:0] v);
        sx = {v[15], v};
    endfunction

    // Alert word address decode, shared by the clear and the read path
    function automatic logic is_alert(input logic [7:0] a);
        is_alert = (a == tras_pkg::OFS_ALERT);
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    logic [7:0] status_r;
    logic [7:0] status_nxt;
    logic hi_arm_r;
    logic hi_arm_nxt;
    logic lo_arm_r;
    logic lo_arm_nxt;
    logic rd_valid_r;
    logic rd_valid_nxt;
    logic rd_alert_r;
    logic rd_alert_nxt;
    logic [7:0] alert_word_r;
    logic [7:0] alert_word_nxt;
    logic [15:0] mem_data;

    logic [16:0] t;
    logic [16:0] hi_lim;
    logic [16:0] hi_rel;
    logic [16:0] lo_lim;
    logic [16:0] lo_rel;
    logic above_hi;
    logic below_hi_band;
    logic below_lo;
    logic above_lo_band;
    logic slew_over;
    logic clr;

    // Extended to 17 bits so threshold plus or minus hysteresis cannot wrap
    assign t = sx(conv.temp);
    assign hi_lim = sx(limits.upper_threshold);
    assign hi_rel = 17'(sx(limits.upper_threshold) - sx(limits.upper_hysteresis));
    assign lo_lim = sx(limits.lower_threshold);
    assign lo_rel = 17'(sx(limits.lower_threshold) + sx(limits.lower_hysteresis));
    assign above_hi = sgt(t, hi_lim);
    assign below_hi_band = sgt(hi_rel, t);
    assign below_lo = sgt(lo_lim, t);
    assign above_lo_band = sgt(t, lo_rel);
    // Sign bit must be clear; negative slew never warns
    assign slew_over = !conv.slew[13] &&
        ($signed(conv.slew) > $signed(limits.slew_limit));

    // Single reads of the alert word clear the sticky bits; burst reads do not
    assign clr = rdreq.rd && !rdreq.burst && is_alert(rdreq.addr);

    // ************************************************************
    // Status next state
    // ************************************************************
    // Clears are applied first so a same-cycle event still sets its flag
    always_comb
    begin
        status_nxt = status_r;
        hi_arm_nxt = hi_arm_r;
        lo_arm_nxt = lo_arm_r;
        if (clr)
        begin
            status_nxt[tras_pkg::BIT_CRC] = 1'b0;
            status_nxt[tras_pkg::BIT_SLEW_FLAG] = 1'b0;
            status_nxt[tras_pkg::BIT_HI_FLAG] = 1'b0;
            status_nxt[tras_pkg::BIT_LO_FLAG] = 1'b0;
            status_nxt[tras_pkg::BIT_READY] = 1'b0;
        end
        if (crc_wr_done && crc_wr_fail)
            status_nxt[tras_pkg::BIT_CRC] = 1'b1;
        if (conv.valid)
        begin
            // All conversion outcomes change in one edge
            status_nxt[tras_pkg::BIT_READY] = 1'b1;
            status_nxt[tras_pkg::BIT_SLEW_LIVE] = slew_over;
            if (slew_over)
                status_nxt[tras_pkg::BIT_SLEW_FLAG] = 1'b1;
            if (above_hi)
                status_nxt[tras_pkg::BIT_HI_LIVE] = 1'b1;
            else if (below_hi_band)
                status_nxt[tras_pkg::BIT_HI_LIVE] = 1'b0;
            if (below_lo)
                status_nxt[tras_pkg::BIT_LO_LIVE] = 1'b1;
            else if (above_lo_band)
                status_nxt[tras_pkg::BIT_LO_LIVE] = 1'b0;
            // Flag fires once per excursion, re-armed by leaving the band
            if (above_hi && hi_arm_r)
            begin
                status_nxt[tras_pkg::BIT_HI_FLAG] = 1'b1;
                hi_arm_nxt = 1'b0;
            end
            else if (below_hi_band)
                hi_arm_nxt = 1'b1;
            if (below_lo && lo_arm_r)
            begin
                status_nxt[tras_pkg::BIT_LO_FLAG] = 1'b1;
                lo_arm_nxt = 1'b0;
            end
            else if (above_lo_band)
                lo_arm_nxt = 1'b1;
        end
    end

    // ************************************************************
    // Read path next state
    // ************************************************************
    // Alert byte captured before the clear lands, so the read sees the flags
    always_comb
    begin
        rd_valid_nxt = rdreq.rd;
        rd_alert_nxt = rd_alert_r;
        alert_word_nxt = alert_word_r;
        if (rdreq.rd)
        begin
            rd_alert_nxt = is_alert(rdreq.addr);
            alert_word_nxt = status_r;
        end
    end

    // Status and read path registers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            status_r <= 8'h00;
            hi_arm_r <= 1'b1;
            lo_arm_r <= 1'b1;
            rd_valid_r <= 1'b0;
            rd_alert_r <= 1'b0;
            alert_word_r <= 8'h00;
        end
        else if (ce)
        begin
            status_r <= status_nxt;
            hi_arm_r <= hi_arm_nxt;
            lo_arm_r <= lo_arm_nxt;
            rd_valid_r <= rd_valid_nxt;
            rd_alert_r <= rd_alert_nxt;
            alert_word_r <= alert_word_nxt;
        end
    end

    // ************************************************************
    // Result storage
    // ************************************************************
    tras_regmem u_mem
    (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .wr(conv.valid),
        .wr_temp(conv.temp),
        .wr_slew({conv.slew, 2'b00}),
        .rd(rdreq.rd),
        .sel(rdreq.addr == tras_pkg::OFS_SLEW),
        .rd_data(mem_data)
    );

    // Unmapped addresses fall to the result store but are forced to zero below
    logic rd_known_r;
    logic rd_known_nxt;
    always_comb
    begin
        rd_known_nxt = rd_known_r;
        if (rdreq.rd)
            rd_known_nxt = (rdreq.addr < 8'(tras_pkg::NUM_REGS));
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            rd_known_r <= 1'b0;
        else if (ce)
            rd_known_r <= rd_known_nxt;
    end

    // Mux after flops; select and data are all registered
    assign rd_data = !rd_known_r ? 16'h0000 :
                     rd_alert_r ? {8'h00, alert_word_r} : mem_data;
    assign rd_valid = rd_valid_r;
    assign over_temp_live_indicator = status_r[tras_pkg::BIT_HI_LIVE];
    assign over_temp_sticky_flag = status_r[tras_pkg::BIT_HI_FLAG];
endmodule

// >>> tb/tras_chk.sv
// Port-level assertion checker for the result and alert block
`timescale 1ns/100ps
module tras_chk
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire tras_pkg::tras_conv_t conv,
    input wire tras_pkg::tras_limits_t limits,
    input wire logic crc_wr_done,
    input wire logic crc_wr_fail,
    input wire tras_pkg::tras_rdreq_t rdreq,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    input wire logic over_temp_live_indicator,
    input wire logic over_temp_sticky_flag
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // ************************************************************
    // Helper terms; 17-bit math so the band edge cannot wrap
    // ************************************************************
    logic go;
    logic rd1;
    logic clr;
    logic signed [16:0] t;
    logic signed [16:0] up;
    logic signed [16:0] band;
    assign go = ce && conv.valid;
    assign rd1 = ce && rdreq.rd;
    assign clr = rd1 && !rdreq.burst && rdreq.addr == tras_pkg::OFS_ALERT;
    assign t = {conv.temp[15], conv.temp};
    assign up = {limits.upper_threshold[15], limits.upper_threshold};
    assign band = up - {limits.upper_hysteresis[15], limits.upper_hysteresis};
    // Answer strobe follows an accepted request by one cycle; a frozen clock holds it
    read_answer_a: assert property (rd1 |=> rd_valid)
        else $error("read not answered next cycle");
    no_answer_a: assert property (ce && !rdreq.rd |=> !rd_valid)
        else $error("answer without a read");
    slew_pad_a: assert property (rd_valid && $past(rdreq.addr) == tras_pkg::OFS_SLEW
        |-> rd_data[1:0] == 2'h0)
        else $error("slew low bits not zero");
    data_hold_a: assert property (!rd1 |=> $stable(rd_data))
        else $error("read data moved without a read");
    hot_set_a: assert property (go && t > up |=> over_temp_live_indicator)
        else $error("live bit not set above threshold");
    cool_clr_a: assert property (go && t < band |=> !over_temp_live_indicator)
        else $error("live bit not cleared below band");
    live_hold_a: assert property (!go |=> $stable(over_temp_live_indicator))
        else $error("live bit moved between conversions");
    flag_set_a: assert property (go && t > up && !over_temp_live_indicator
        |=> over_temp_sticky_flag)
        else $error("sticky flag not set on crossing");
    flag_once_a: assert property (over_temp_live_indicator && !over_temp_sticky_flag
        |=> !over_temp_sticky_flag)
        else $error("sticky flag set twice in one excursion");
    flag_clear_a: assert property (clr && !go |=> !over_temp_sticky_flag)
        else $error("status read did not clear flag");
    burst_keep_a: assert property (rd1 && rdreq.burst && over_temp_sticky_flag
        |=> over_temp_sticky_flag)
        else $error("burst read cleared flag");
endmodule
bind tras_top tras_chk u_chk (.mclk, .rst, .ce, .conv, .limits, .crc_wr_done,
    .crc_wr_fail, .rdreq, .rd_data, .rd_valid, .over_temp_live_indicator,
    .over_temp_sticky_flag);

// >>> tb/tras_host.sv
// Serial controller model that issues register reads
`timescale 1ns/100ps
module tras_host
(
    input wire logic mclk,
    output tras_pkg::tras_rdreq_t rdreq,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid
);
    initial rdreq = '0;
    // One-cycle request; released address is inverted so stale values never match
    task automatic rd(input logic b, input logic [7:0] a, output logic [15:0] d,
        output logic v);
        @(posedge mclk);
        #1 rdreq = {1'b1, b, a};
        @(posedge mclk);
        #1 rdreq = {1'b0, b, ~a};
        v = rd_valid;
        d = rd_data;
    endtask
endmodule

// >>> tb/tb.sv
// Directed testbench for the result and alert block
`timescale 1ns/100ps
module tb;
    logic mclk;
    logic rst = 1'b1;
    logic ce = 1'b1;
    tras_pkg::tras_conv_t conv = '0;
    tras_pkg::tras_limits_t limits = {16'h1000, 16'h0100, 16'hF000, 16'h0100, 14'h0100};
    logic crc_wr_done = 1'b0;
    logic crc_wr_fail = 1'b0;
    tras_pkg::tras_rdreq_t rdreq;
    logic [15:0] rd_data;
    logic rd_valid;
    logic live;
    logic sticky;
    int fails = 0;
    int compares = 0;
    tras_top DUT (.mclk(mclk), .rst(rst), .ce(ce), .conv(conv), .limits(limits),
        .crc_wr_done(crc_wr_done), .crc_wr_fail(crc_wr_fail), .rdreq(rdreq),
        .rd_data(rd_data), .rd_valid(rd_valid), .over_temp_live_indicator(live),
        .over_temp_sticky_flag(sticky));
    tras_host host (.mclk(mclk), .rdreq(rdreq), .rd_data(rd_data), .rd_valid(rd_valid));
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic stop_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One read and compare of data and answer strobe
    task automatic chk(input logic b, input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic v;
        host.rd(b, a, d, v);
        compares++;
        if (v !== 1'b1 || d !== e)
        begin
            fails++;
            $display("CHECK FAILED %0t addr %h got %h exp %h", $time, a, d, e);
        end
    endtask
    task automatic cnv(input logic [15:0] t, input logic [13:0] s);
        @(posedge mclk);
        #1 conv = {1'b1, t, s};
        @(posedge mclk);
        #1 conv = '0;
    endtask
    task automatic crc(input logic f);
        @(posedge mclk);
        #1 crc_wr_done = 1'b1;
        crc_wr_fail = f;
        @(posedge mclk);
        #1 crc_wr_done = 1'b0;
    endtask
    // ************************************************************
    // Test sequence
    // ************************************************************
    initial
    begin
        repeat (3) @(posedge mclk);
        #1 rst = 1'b0;
        chk(0, 8'h00, 16'h0000);
        chk(0, 8'h01, 16'h0000);
        chk(0, 8'h02, 16'h0000);
        $display("end of test: reset");
        cnv(16'h1234, 14'h0ABC);
        chk(1, 8'h00, 16'h1234);
        chk(1, 8'h01, 16'h2AF0);
        chk(1, 8'h02, 16'h0075);
        chk(0, 8'h02, 16'h0075);
        chk(0, 8'h02, 16'h0050);
        chk(0, 8'h03, 16'h0000);
        compares++;
        if ({live, sticky} !== 2'b10)
        begin
            fails++;
            $display("CHECK FAILED %0t live or sticky pin", $time);
        end
        $display("end of test: results");
        cnv(16'h1100, 14'h3F00);
        chk(0, 8'h02, 16'h0011);
        cnv(16'h0E00, 14'h0100);
        chk(0, 8'h02, 16'h0001);
        cnv(16'h1001, 14'h0000);
        chk(0, 8'h02, 16'h0015);
        cnv(16'hEFFF, 14'h0000);
        chk(0, 8'h02, 16'h000B);
        cnv(16'hF080, 14'h0000);
        chk(0, 8'h02, 16'h0009);
        cnv(16'hF101, 14'h0000);
        chk(0, 8'h02, 16'h0001);
        $display("end of test: thresholds");
        crc(1'b0);
        chk(0, 8'h02, 16'h0000);
        crc(1'b1);
        chk(0, 8'h02, 16'h0080);
        chk(0, 8'h02, 16'h0000);
        $display("end of test: crc");
        @(posedge mclk);
        #1 ce = 1'b0;
        cnv(16'h0500, 14'h0100);
        ce = 1'b1;
        chk(0, 8'h00, 16'hF101);
        chk(0, 8'h02, 16'h0000);
        $display("end of test: freeze");
        stop_test();
    end
    // Whole run is under a hundred cycles; this span is far beyond it
    initial
    begin
        #50000;
        fails++;
        stop_test();
    end
endmodule
